/* File: src/sfb_pkg.sv */
// Shared constants and types of the serial flash bus front end
package sfb_pkg;
  localparam logic [7:0]  CMD_DUAL_OUT   = 8'h3b;
  localparam logic [7:0]  CMD_DUAL_IO    = 8'hbb;
  localparam logic [7:0]  CMD_QUAD_OUT   = 8'h6b;
  localparam logic [7:0]  CMD_QUAD_IO    = 8'heb;
  localparam logic [7:0]  CMD_WORD_QUAD  = 8'he7;
  localparam logic [7:0]  CMD_OCTAL_QUAD = 8'he3;
  localparam logic [7:0]  CMD_QPI_ENTER  = 8'h38;
  localparam logic [7:0]  CMD_QPI_EXIT   = 8'hff;
  localparam logic [7:0]  CMD_SOFT_RESET = 8'h99;
  localparam int          ADDR_W         = 18;
  localparam logic [17:0] ADDR_TOP       = 18'h3ffff;
  localparam int          PAGE_COUNT     = 1024;
  localparam int          PAGE_BYTES     = 256;
  localparam int          SECTOR_COUNT   = 64;
  localparam int          SECTOR_SHIFT   = 12;
  localparam int          BLK32_SHIFT    = 15;
  localparam int          BLK64_SHIFT    = 16;
  localparam logic [2:0]  CNT_SINGLE     = 3'h7;
  localparam logic [2:0]  CNT_DUAL       = 3'h3;
  localparam logic [2:0]  CNT_QUAD       = 3'h1;

  typedef enum logic [1:0] {LANE_X1, LANE_X2, LANE_X4} sfb_width_t;

  // One assembled unit handed to the core
  typedef struct packed {
    logic [7:0] data;
    logic       is_cmd;
  } sfb_unit_t;
endpackage

/* File: src/sfb_bus_if.sv */
// Serial flash bus front end: pin sampling, lane shifter, mode control
`timescale 1ns/1ns
module sfb_bus_if #(
  parameter int DATA_W = 8                        // Unit width
) (
  input  wire logic       CLK_I,                  // System clock, 10 MHz
  input  wire logic       RST_N_I,                // Synchronous reset, active low
  input  wire logic       CS_N_I,                 // Chip select pin, active low
  input  wire logic       SCK_I,                  // Serial clock pin
  input  wire logic [3:0] IO_LANE_I,              // Lanes 0..3 pin levels
  output logic      [3:0] IO_LANE_O,              // Lanes 0..3 drive values
  output logic      [3:0] IO_LANE_OE_O,           // Lanes 0..3 drive enables
  input  wire logic       QUAD_ENABLE_BIT_I,      // Non-volatile quad enable
  input  wire logic [1:0] STATUS_GUARD_BITS_I,    // Status register guard bits
  output logic            STATUS_WRITE_BLOCK_O,   // Status writes blocked
  output logic            FOUR_LANE_MODE_O,       // Four-lane command mode active
  output logic            PAUSED_O,               // Pause condition active
  output logic            SELECTED_O,             // Bus armed and selected
  output logic [7:0]      RX_DATA_O,              // Received unit
  output logic            RX_IS_CMD_O,            // Unit is an instruction
  output logic            RX_VALID_O,             // Received unit valid
  input  wire logic       RX_READY_I,             // Core accepts unit
  input  wire logic [7:0] TX_DATA_I,              // Byte to send
  input  wire logic       TX_VALID_I,             // Send byte valid
  output logic            TX_READY_O,             // Front end takes send byte
  input  wire logic [1:0] TX_WIDTH_I,             // Lanes for send: 0 x1, 1 x2, 2 x4
  input  wire logic [1:0] RX_WIDTH_I,             // Lanes after the opcode
  input  wire logic       CORE_BUSY_I,            // Program or erase in progress
  output logic            QUAD_REJECT_O           // Quad command refused pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change once stages two and three agree
  logic [2:0] cs_s, sck_s;
  logic [2:0] io_s [4];
  logic       cs_n, sck, sck_q;
  logic [3:0] io_in;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cs_s  <= 3'h0;  // Low until the pin is seen high: no false edge
      sck_s <= 3'h0;
      for (int i = 0; i < 4; i++) io_s[i] <= 3'h7;
    end else begin
      cs_s  <= {cs_s[1:0], CS_N_I};
      sck_s <= {sck_s[1:0], SCK_I};
      for (int i = 0; i < 4; i++) io_s[i] <= {io_s[i][1:0], IO_LANE_I[i]};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      cs_n  <= 1'b0;
      sck   <= 1'b0;
      sck_q <= 1'b0;
      io_in <= 4'hf;
    end else begin
      if (cs_s[1] == cs_s[2]) cs_n <= cs_s[2];
      if (sck_s[1] == sck_s[2]) sck <= sck_s[2];
      sck_q <= sck;
      for (int i = 0; i < 4; i++)
        if (io_s[i][1] == io_s[i][2]) io_in[i] <= io_s[i][2];
    end
  end

  logic cs_n_q;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) cs_n_q <= 1'b0;
    else          cs_n_q <= cs_n;
  end

  wire cs_fall = cs_n_q && !cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // Arming after reset and pause control
  logic armed, paused, four_lane;
  sfb_pkg::sfb_width_t rx_w, tx_w, cur_w;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I)     armed <= 1'b0;
    else if (cs_fall) armed <= 1'b1;
  end

  wire selected   = armed && !cs_n;
  wire pause_pin  = io_in[3];
  wire pause_ok   = !QUAD_ENABLE_BIT_I && !four_lane && cur_w != sfb_pkg::LANE_X4;
  wire sck_rise   = !sck_q && sck && selected && !paused;
  wire sck_fall   = sck_q && !sck && selected && !paused;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || cs_n || !pause_ok) paused <= 1'b0;
    else if (!sck)                     paused <= !pause_pin;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry receive buffer
  sfb_pkg::sfb_unit_t buf_mem [2];
  logic       wr_ptr, rd_ptr;
  logic [1:0] fill;
  logic       push;
  sfb_pkg::sfb_unit_t push_unit;
  wire        buf_full = fill == 2'h2;
  wire        pop      = RX_VALID_O && RX_READY_I;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      fill   <= 2'h0;
    end else begin
      if (push && !buf_full) begin
        buf_mem[wr_ptr] <= push_unit;
        wr_ptr          <= !wr_ptr;
      end
      if (pop) rd_ptr <= !rd_ptr;
      fill <= fill + 2'((push && !buf_full) ? 1 : 0) - 2'(pop ? 1 : 0);
    end
  end

  assign RX_VALID_O  = fill != 2'h0;
  assign RX_DATA_O   = buf_mem[rd_ptr].data;
  assign RX_IS_CMD_O = buf_mem[rd_ptr].is_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter, msb first, top lane holds top bit
  function automatic logic [2:0] last_cnt(input sfb_pkg::sfb_width_t w);
    case (w)
      sfb_pkg::LANE_X2: last_cnt = sfb_pkg::CNT_DUAL;
      sfb_pkg::LANE_X4: last_cnt = sfb_pkg::CNT_QUAD;
      default:          last_cnt = sfb_pkg::CNT_SINGLE;
    endcase
  endfunction

  function automatic sfb_pkg::sfb_width_t to_w(input logic [1:0] c);
    case (c)
      2'h1:    to_w = sfb_pkg::LANE_X2;
      2'h2:    to_w = sfb_pkg::LANE_X4;
      default: to_w = sfb_pkg::LANE_X1;
    endcase
  endfunction

  logic [7:0] rx_sh;
  logic [2:0] rx_cnt;
  logic       first_unit;
  wire  [7:0] next_rx_sh = (rx_w == sfb_pkg::LANE_X4) ? {rx_sh[3:0], io_in} :
                           (rx_w == sfb_pkg::LANE_X2) ? {rx_sh[5:0], io_in[1:0]} :
                           {rx_sh[6:0], io_in[0]};
  wire        unit_done  = sck_rise && rx_cnt == last_cnt(rx_w);
  wire        quad_cmd   = next_rx_sh == sfb_pkg::CMD_QUAD_OUT ||
                           next_rx_sh == sfb_pkg::CMD_QUAD_IO ||
                           next_rx_sh == sfb_pkg::CMD_WORD_QUAD ||
                           next_rx_sh == sfb_pkg::CMD_OCTAL_QUAD;
  wire        reject     = unit_done && first_unit && !four_lane &&
                           quad_cmd && !QUAD_ENABLE_BIT_I;
  logic       discard;

  assign push      = unit_done && !reject && !discard && !CORE_BUSY_I;
  assign push_unit = '{data: next_rx_sh, is_cmd: first_unit};

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || cs_n) begin
      rx_sh      <= 8'h00;
      rx_cnt     <= 3'h0;
      first_unit <= 1'b1;
      discard    <= 1'b0;
      rx_w       <= sfb_pkg::LANE_X1;
    end else begin
      if (!first_unit || rx_cnt != 3'h0) rx_w <= rx_w;
      else rx_w <= four_lane ? sfb_pkg::LANE_X4 : sfb_pkg::LANE_X1;
      if (sck_rise) begin
        rx_sh  <= next_rx_sh;
        rx_cnt <= unit_done ? 3'h0 : rx_cnt + 3'h1;
      end
      if (unit_done) begin
        first_unit <= 1'b0;
        if (first_unit) rx_w <= four_lane ? sfb_pkg::LANE_X4 : to_w(RX_WIDTH_I);
        if (reject) discard <= 1'b1;
      end
    end
  end

  assign QUAD_REJECT_O = reject;

  // Array address from the three bytes after the opcode, top bits dropped
  logic [sfb_pkg::ADDR_W-1:0] addr;
  logic [1:0]                 addr_n;
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || cs_n) begin
      addr   <= '0;
      addr_n <= 2'h0;
    end else if (push && !first_unit && addr_n != 2'h3) begin
      addr   <= {addr[sfb_pkg::ADDR_W-9:0], next_rx_sh};
      addr_n <= addr_n + 2'h1;
    end
  end
  wire [9:0] page_idx   = addr[sfb_pkg::ADDR_W-1:$clog2(sfb_pkg::PAGE_BYTES)];
  wire [5:0] sector_idx = addr[sfb_pkg::ADDR_W-1:sfb_pkg::SECTOR_SHIFT];
  wire [2:0] blk32_idx  = addr[sfb_pkg::ADDR_W-1:sfb_pkg::BLK32_SHIFT];
  wire [1:0] blk64_idx  = addr[sfb_pkg::ADDR_W-1:sfb_pkg::BLK64_SHIFT];

  ////////////////////////////////////////////////////////////////////////////
  // Mode family: four-lane command mode enter and leave
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      four_lane <= 1'b0;
    end else if (unit_done && first_unit) begin
      if (next_rx_sh == sfb_pkg::CMD_SOFT_RESET) four_lane <= 1'b0;
      else if (next_rx_sh == sfb_pkg::CMD_QPI_EXIT) four_lane <= 1'b0;
      else if (next_rx_sh == sfb_pkg::CMD_QPI_ENTER && QUAD_ENABLE_BIT_I)
        four_lane <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shifter, launched on falling edges
  logic [7:0] tx_sh;
  logic [2:0] tx_cnt;
  logic       tx_act;
  logic [3:0] drv_val, drv_en;

  assign cur_w      = tx_act ? tx_w : rx_w;
  assign TX_READY_O = selected && !paused && sck_fall &&
                      (!tx_act || tx_cnt == last_cnt(tx_w));

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I || cs_n) begin
      tx_sh   <= 8'h00;
      tx_cnt  <= 3'h0;
      tx_act  <= 1'b0;
      tx_w    <= sfb_pkg::LANE_X1;
      drv_val <= 4'h0;
      drv_en  <= 4'h0;
    end else if (sck_fall) begin
      if (TX_READY_O && TX_VALID_I) begin
        tx_act <= 1'b1;
        tx_w   <= four_lane ? sfb_pkg::LANE_X4 : to_w(TX_WIDTH_I);
        tx_cnt <= 3'h0;
        case (four_lane ? sfb_pkg::LANE_X4 : to_w(TX_WIDTH_I))
          sfb_pkg::LANE_X4: begin
            drv_val <= TX_DATA_I[7:4];
            drv_en  <= 4'hf;
            tx_sh   <= {TX_DATA_I[3:0], 4'h0};
          end
          sfb_pkg::LANE_X2: begin
            drv_val <= {2'h0, TX_DATA_I[7:6]};
            drv_en  <= 4'h3;
            tx_sh   <= {TX_DATA_I[5:0], 2'h0};
          end
          default: begin
            drv_val <= {2'h0, TX_DATA_I[7], 1'b0};
            drv_en  <= 4'h2;
            tx_sh   <= {TX_DATA_I[6:0], 1'b0};
          end
        endcase
      end else if (tx_act && tx_cnt != last_cnt(tx_w)) begin
        tx_cnt <= tx_cnt + 3'h1;
        case (tx_w)
          sfb_pkg::LANE_X4: begin
            drv_val <= tx_sh[7:4];
            tx_sh   <= {tx_sh[3:0], 4'h0};
          end
          sfb_pkg::LANE_X2: begin
            drv_val <= {2'h0, tx_sh[7:6]};
            tx_sh   <= {tx_sh[5:0], 2'h0};
          end
          default: begin
            drv_val <= {2'h0, tx_sh[7], 1'b0};
            tx_sh   <= {tx_sh[6:0], 1'b0};
          end
        endcase
      end else begin
        tx_act <= 1'b0;
        drv_en <= 4'h0;
      end
    end
  end

  assign IO_LANE_O    = drv_val;
  assign IO_LANE_OE_O = (selected && !paused) ? drv_en : 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs
  wire guard_active = !QUAD_ENABLE_BIT_I && !four_lane;
  assign STATUS_WRITE_BLOCK_O = guard_active && !io_in[2] &&
                                STATUS_GUARD_BITS_I[0];
  assign FOUR_LANE_MODE_O = four_lane;
  assign PAUSED_O         = paused;
  assign SELECTED_O       = selected;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  deselect_float_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    cs_n |-> IO_LANE_OE_O == 4'h0) else $error("lanes driven while deselected");
  pause_float_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    paused |-> IO_LANE_OE_O == 4'h0 && !push) else $error("activity during pause");
  pause_quad_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    QUAD_ENABLE_BIT_I |=> !paused) else $error("pause with quad enable");
  arm_first_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    !armed |-> !push && IO_LANE_OE_O == 4'h0) else $error("activity before arming");
  qpi_entry_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $rose(four_lane) |-> $past(QUAD_ENABLE_BIT_I)) else $error("bad four-lane entry");
  quad_reject_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    reject |-> !QUAD_ENABLE_BIT_I ##1 discard) else $error("quad reject wrong");
  guard_off_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    QUAD_ENABLE_BIT_I |-> !STATUS_WRITE_BLOCK_O) else $error("guard with quad enable");
  sequence fall_edge_s;
    sck_q && !sck && selected && !paused;
  endsequence
  drive_fall_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $changed(drv_val) && !cs_n_q |-> $past(sck_q && !sck)) else $error("drive off fall");
  pause_low_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
    $rose(paused) |-> !$past(sck)) else $error("pause began with clock high");
  unused_seq_a: cover property (@(posedge CLK_I) fall_edge_s);

endmodule

/* File: sim/sfb_master_model.sv */
// Bus master model driving the serial flash front end pins
`timescale 1ns/1ns
module sfb_master_model #(
  parameter int HALF = 8             // Serial clock half period in system clocks
) (
  input  wire logic [3:0] dut_i,     // Device lane values
  input  wire logic [3:0] oe_i,      // Device lane enables
  input  wire logic       clk_i,     // System clock
  output logic            cs_n_o,    // Chip select
  output logic            sck_o,     // Serial clock
  output logic [3:0]      lane_o     // Resolved lane levels
);
  logic [3:0] m_val = 4'hf;
  logic [3:0] m_oe  = 4'hc;
  logic       pin2  = 1'b1;
  logic       pin3  = 1'b1;
  logic       idle  = 1'b0;
  logic       flt   = 1'b0;
  initial begin
    cs_n_o = 1'b0;  // Selected from power-up to probe arming
    sck_o = 1'b0;
  end
  always @(posedge clk_i) flt <= ~flt;
  // Released lanes show a toggling level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_o[i] = oe_i[i] ? dut_i[i] : (m_oe[i] ? m_val[i] : flt);
    end
  end
  task automatic hw(input int n = HALF);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic start(input logic mode3);
    idle = mode3;
    sck_o = mode3;
    hw();
    cs_n_o = 1'b0;
    hw();
  endtask
  task automatic stop();
    sck_o = idle;
    hw();
    cs_n_o = 1'b1;
    m_oe = 4'hc;
    m_val = {pin3, pin2, 2'b11};
    hw(2 * HALF);
  endtask
  // Guard and pause pins only move while the clock is low
  task automatic pause(input logic p2, input logic p3);
    sck_o = 1'b0;
    hw();
    pin2 = p2;
    pin3 = p3;
    m_val[3:2] = {p3, p2};
    hw();
  endtask
  task automatic xfer(input logic [7:0] dout, input int w, input logic drv,
                      output logic [7:0] din);
    logic [3:0] msk;
    logic [3:0] hold;
    logic [7:0] sh;
    msk = (w == 4) ? 4'hf : ((w == 2) ? 4'h3 : 4'h1);
    hold = (w == 4) ? 4'h0 : 4'hc;
    sh = dout;
    din = 8'h00;
    for (int s = 0; s < 8 / w; s++) begin
      sck_o = 1'b0;
      m_oe = hold | (drv ? msk : 4'h0);
      m_val = ({pin3, pin2, 2'b00} & hold) | (sh[7:4] >> (4 - w));
      sh = sh << w;
      hw();
      din = (din << w) | 8'((lane_o >> (w == 1)) & msk);
      sck_o = 1'b1;
      hw();
    end
  endtask
endmodule

/* File: sim/tb.sv */
// Self-checking bench for the serial flash bus front end
`timescale 1ns/1ns
module tb;
  localparam int LIMIT = 60000;
  logic       clk, rst_n, qe, rx_ready, tx_valid, core_busy;
  logic       cs_n, sck, blk, four, paused, sel, rx_cmd, rx_valid, tx_ready, reject;
  logic [3:0] lane, dut_o, dut_oe;
  logic [7:0] rx_data, d, tx_data;
  logic [1:0] tx_width, rx_width, gbits;
  int         n_mismatch = 0, checks_done = 0, n_reject = 0, cyc = 0;
  sfb_pkg::sfb_unit_t rxq[$];
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  sfb_bus_if i_dut (
    .CLK_I(clk), .RST_N_I(rst_n), .CS_N_I(cs_n), .SCK_I(sck), .IO_LANE_I(lane),
    .IO_LANE_O(dut_o), .IO_LANE_OE_O(dut_oe), .QUAD_ENABLE_BIT_I(qe),
    .STATUS_GUARD_BITS_I(gbits), .STATUS_WRITE_BLOCK_O(blk), .FOUR_LANE_MODE_O(four),
    .PAUSED_O(paused), .SELECTED_O(sel), .RX_DATA_O(rx_data), .RX_IS_CMD_O(rx_cmd),
    .RX_VALID_O(rx_valid), .RX_READY_I(rx_ready), .TX_DATA_I(tx_data),
    .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .TX_WIDTH_I(tx_width),
    .RX_WIDTH_I(rx_width), .CORE_BUSY_I(core_busy), .QUAD_REJECT_O(reject));
  sfb_master_model i_m (.dut_i(dut_o), .oe_i(dut_oe), .clk_i(clk), .cs_n_o(cs_n),
    .sck_o(sck), .lane_o(lane));
  always @(posedge clk) begin
    if (rx_valid === 1'b1 && rx_ready) rxq.push_back({rx_data, rx_cmd});
    if (reject === 1'b1) n_reject++;
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    chk8(what, {7'h00, exp}, {7'h00, got});
  endtask
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Offer one send byte, hold it until the ready pulse has been taken
  task automatic send(input logic [7:0] dv, input logic [1:0] wv);
    tx_data  = dv;
    tx_width = wv;
    tx_valid = 1'b1;
    while (tx_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask
  task automatic unit(input logic [7:0] dv, input logic cv);
    sfb_pkg::sfb_unit_t u;
    u = '1;
    if (rxq.size() > 0) u = rxq.pop_front();
    chk8("rx data", dv, u.data);
    chk1("rx is_cmd", cv, u.is_cmd);
  endtask
  task automatic frame(input logic [7:0] op, input int w);
    i_m.start(1'b0);
    i_m.xfer(op, w, 1'b1, d);
    i_m.stop();
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_arm();
    i_m.xfer(8'h9f, 1, 1'b1, d);
    chk1("armed", 1'b0, sel);
    i_m.stop();
    chk8("units", 8'h00, 8'(rxq.size()));
    i_m.start(1'b0);
    i_m.xfer(8'h9f, 1, 1'b1, d);
    chk1("selected", 1'b1, sel);
    i_m.xfer(8'h3c, 1, 1'b1, d);
    i_m.stop();
    unit(8'h9f, 1'b1);
    unit(8'h3c, 1'b0);
    chk8("lane enables", 8'h00, {4'h0, dut_oe});
    chk1("four lane", 1'b0, four);
    $display("t_arm done");
  endtask
  task automatic t_read();
    for (int m = 0; m < 2; m++) begin
      i_m.start(m[0]);
      i_m.xfer(8'h0b, 1, 1'b1, d);
      fork
        i_m.xfer(8'h00, 1, 1'b0, d);
        send(8'ha5 ^ 8'(m), 2'h0);
      join
      chk8("read x1", 8'ha5 ^ 8'(m), d);
      i_m.stop();
      unit(8'h0b, 1'b1);
      rxq.delete();
    end
    $display("t_read done");
  endtask
  // Address 06d5a3 wraps to 2d5a3: page 2d5, sector 45, blocks 5 and 2
  task automatic t_addr();
    i_m.start(1'b1);
    i_m.xfer(8'h03, 1, 1'b1, d);
    i_m.xfer(8'h06, 1, 1'b1, d);
    i_m.xfer(8'hd5, 1, 1'b1, d);
    i_m.xfer(8'ha3, 1, 1'b1, d);
    i_m.xfer(8'h5a, 1, 1'b1, d);
    chk16("page", 16'h02d5, 16'(i_dut.page_idx));
    chk16("sector", 16'h002d, 16'(i_dut.sector_idx));
    chk16("block 32k", 16'h0005, 16'(i_dut.blk32_idx));
    chk16("block 64k", 16'h0002, 16'(i_dut.blk64_idx));
    i_m.stop();
    rxq.delete();
    $display("t_addr done");
  endtask
  task automatic t_pause();
    i_m.start(1'b0);
    i_m.xfer(8'h0b, 1, 1'b1, d);
    fork
      i_m.pause(1'b1, 1'b0);
      send(8'h6d, 2'h0);
    join
    chk1("paused", 1'b1, paused);
    chk1("out lane", 1'b0, dut_oe[1]);
    i_m.xfer(8'hff, 1, 1'b1, d);
    unit(8'h0b, 1'b1);
    chk8("units", 8'h00, 8'(rxq.size()));
    i_m.pause(1'b1, 1'b1);
    chk1("resumed", 1'b0, paused);
    i_m.xfer(8'h00, 1, 1'b0, d);
    chk8("read after pause", 8'h6d, d);
    i_m.stop();
    rxq.delete();
    $display("t_pause done");
  endtask
  task automatic t_lanes();
    logic [7:0] ops[6] = '{8'h3b, 8'hbb, 8'h6b, 8'heb, 8'he7, 8'he3};
    int         w;
    gbits = 2'h1;
    i_m.pause(1'b0, 1'b1);
    chk1("guard", 1'b1, blk);
    frame(8'h6b, 1);
    chk8("rejects", 8'h01, 8'(n_reject));
    rxq.delete();
    qe = 1'b1;
    i_m.hw(4);
    chk1("guard off", 1'b0, blk);
    i_m.start(1'b0);
    i_m.pause(1'b1, 1'b0);
    chk1("pause off", 1'b0, paused);
    i_m.pause(1'b1, 1'b1);
    i_m.stop();
    for (int i = 0; i < 6; i++) begin
      w = (i < 2) ? 2 : 4;
      rx_width = (i < 2) ? 2'h1 : 2'h2;
      i_m.start(1'b0);
      i_m.xfer(ops[i], 1, 1'b1, d);
      i_m.xfer(8'hc3 ^ 8'(i), w, 1'b1, d);
      fork
        i_m.xfer(8'h00, w, 1'b0, d);
        send(8'h96 ^ 8'(i), rx_width);
      join
      chk8("read multi", 8'h96 ^ 8'(i), d);
      i_m.stop();
      unit(ops[i], 1'b1);
      unit(8'hc3 ^ 8'(i), 1'b0);
      rxq.delete();
    end
    $display("t_lanes done");
  endtask
  task automatic t_qpi();
    logic [7:0] ops[6] = '{8'h38, 8'h38, 8'h9f, 8'hff, 8'h38, 8'h99};
    logic [5:0] exp = 6'b010110;
    for (int i = 0; i < 6; i++) begin
      qe = (i > 0);
      frame(ops[i], (i > 0 && exp[i - 1]) ? 4 : 1);
      chk1("four lane", exp[i], four);
      if (i == 2) unit(8'h9f, 1'b1);
      rxq.delete();
    end
    $display("t_qpi done");
  endtask
  task automatic t_buffer();
    rx_width = 2'h0;
    rx_ready = 1'b0;
    i_m.start(1'b0);
    i_m.xfer(8'h9f, 1, 1'b1, d);
    i_m.xfer(8'h11, 1, 1'b1, d);
    i_m.xfer(8'h22, 1, 1'b1, d);
    i_m.stop();
    chk1("full valid", 1'b1, rx_valid);
    rx_ready = 1'b1;
    i_m.hw(4);
    unit(8'h9f, 1'b1);
    unit(8'h11, 1'b0);
    chk8("units", 8'h00, 8'(rxq.size()));
    chk1("drained", 1'b0, rx_valid);
    core_busy = 1'b1;
    frame(8'h9f, 1);
    chk8("busy units", 8'h00, 8'(rxq.size()));
    core_busy = 1'b0;
    $display("t_buffer done");
  endtask
  initial begin
    rst_n     = 1'b0;
    qe        = 1'b0;
    rx_ready  = 1'b1;
    tx_valid  = 1'b0;
    core_busy = 1'b0;
    tx_data   = 8'h00;
    tx_width  = 2'h0;
    rx_width  = 2'h0;
    gbits     = 2'h0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_arm();
    t_read();
    t_addr();
    t_pause();
    t_lanes();
    t_qpi();
    t_buffer();
    results();
  end
endmodule
